// ---- core/bdrb_pkg.sv ----
// ****************************************************************
// bias DAC register bank: shared constants and types
// ****************************************************************
package bdrb_pkg;

  localparam int ADDR_W = 5;

  // register offsets
  localparam logic [4:0] OFS_GLOBAL_CONTROL = 5'h00;
  localparam logic [4:0] OFS_CARRIER_REF = 5'h01;
  localparam logic [4:0] OFS_CARRIER_DRV = 5'h02;
  localparam logic [4:0] OFS_CARRIER_FIN = 5'h03;
  localparam logic [4:0] OFS_PEAKING_REF = 5'h04;
  localparam logic [4:0] OFS_PEAKING_DRV = 5'h05;
  localparam logic [4:0] OFS_PEAKING_FIN = 5'h06;
  localparam logic [4:0] OFS_THERMAL = 5'h0F;
  localparam logic [4:0] OFS_UNLOCK_KEY = 5'h11;

  // global_control field positions
  localparam int CTRL_SOFT_RST_BIT = 6;
  localparam int CTRL_REFRESH_BIT = 5;
  localparam int CTRL_REV_LSB = 0;
  localparam int CTRL_REV_W = 4;

  // revision code, value is arbitrary
  localparam logic [3:0] REVISION_CODE = 4'h6;

  localparam logic [7:0] UNLOCK_KEY = 8'hE3;

  // values after reset
  localparam logic [5:0] CARRIER_REF_RST = 6'h20;
  localparam logic [7:0] CARRIER_DRV_RST = 8'h80;
  localparam logic [7:0] CARRIER_FIN_RST = 8'h80;
  localparam logic [5:0] PEAKING_REF_RST = 6'h20;
  localparam logic [7:0] PEAKING_DRV_RST = 8'h80;
  localparam logic [7:0] PEAKING_FIN_RST = 8'h80;
  localparam logic [7:0] THERMAL_RST = 8'h00;
  localparam logic [1:0] CTRL_REQ_RST = 2'h0;

  // fuse copy waits until the three-stage input filter has settled
  localparam logic [2:0] SETTLE_CYCLES = 3'h5;

  typedef struct packed {
    logic [5:0] carrier_ref;
    logic [7:0] carrier_drv;
    logic [7:0] carrier_fin;
    logic [5:0] peaking_ref;
    logic [7:0] peaking_drv;
    logic [7:0] peaking_fin;
  } bdrb_dac_s;

  typedef struct packed {
    logic programmed;
    bdrb_dac_s dac;
  } bdrb_otp_s;

  localparam bdrb_dac_s DAC_RST = '{
    carrier_ref: CARRIER_REF_RST,
    carrier_drv: CARRIER_DRV_RST,
    carrier_fin: CARRIER_FIN_RST,
    peaking_ref: PEAKING_REF_RST,
    peaking_drv: PEAKING_DRV_RST,
    peaking_fin: PEAKING_FIN_RST
  };

  typedef enum logic [1:0] {
    BDRB_IDLE = 2'h0,
    BDRB_SETTLE = 2'h1,
    BDRB_COPY = 2'h3
  } bdrb_load_e;

endpackage

// ---- core/bdrb_sync.sv ----
`timescale 1ns/10ps
// ****************************************************************
// three-stage input filter for signals from outside core_clk
// ****************************************************************
module bdrb_sync #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // stage1 is only seen by stage2; a change counts once 2 and 3 agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_out <= '0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule

// ---- core/bdrb_bank.sv ----
`timescale 1ns/10ps
// What this block does
// - writing 1 to control bit 6 returns DAC registers, thermal reading and override mode to defaults
// - writing 1 to control bit 5 recopies fuse values into fuse registers
// - control bits 0 to 3 show a fixed revision, writes ignored
// - address 1: 6-bit carrier reference, default 6'h20, override writes only
// - address 4: 6-bit peaking reference, fuse loaded, override writes only
// - addresses 2 and 3: carrier gate offsets, default 8'h80, override only
// - addresses 5 and 6: peaking gate offsets, final default 8'h80
// - gate offset code passes unchanged; larger code means lower gate
// - address 15: read-only thermal reading, resets to 8'h00
// - writing 8'hE3 to address 17 enters override mode; nothing readable
// - any other byte written to address 17 leaves override mode at once
// - in override mode addresses 1 to 6 accept writes
// - outside override mode DAC writes are dropped; reads always allowed
// - at reset the fuse contents load into fuse-loaded registers
// - defaults stay only when the fuse store is unprogrammed
module bdrb_bank (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_busy,
  output logic reg_wr_refused,
  input wire bdrb_pkg::bdrb_otp_s otp_in,
  input wire logic [7:0] thermal_in,
  output bdrb_pkg::bdrb_dac_s dac_out,
  output logic override_mode,
  output logic fuse_loaded
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_dac_addr(input logic [4:0] addr);
    is_dac_addr = (addr >= bdrb_pkg::OFS_CARRIER_REF) &&
                  (addr <= bdrb_pkg::OFS_PEAKING_FIN);
  endfunction

  function automatic logic [7:0] pad6(input logic [5:0] val);
    pad6 = {2'h0, val};
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  bdrb_pkg::bdrb_otp_s otp_sync;
  logic [7:0] thermal_sync;
  bdrb_pkg::bdrb_dac_s dac;
  logic [7:0] thermal_reading;
  logic [1:0] ctrl_req;
  bdrb_pkg::bdrb_load_e load_state;
  bdrb_pkg::bdrb_load_e next_load_state;
  logic [2:0] settle_cnt;
  logic wr_ok;
  logic ctrl_wr;
  logic key_wr;
  logic dac_wr;
  logic soft_rst_req;
  logic refresh_req;
  logic reload_start;
  logic [7:0] next_rdata;

  // ****************************************************************
  // input filtering
  // ****************************************************************
  // the fuse outputs and the thermal converter sit outside core_clk
  bdrb_sync #(
    .W($bits(bdrb_pkg::bdrb_otp_s))
  ) u_otp_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(otp_in),
    .sync_out(otp_sync)
  );

  bdrb_sync #(
    .W(8)
  ) u_thermal_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(thermal_in),
    .sync_out(thermal_sync)
  );

  // ****************************************************************
  // write decode
  // ****************************************************************
  // writes are refused while the fuse copy runs so that a host value
  // is never overwritten half way through a reload
  assign reg_busy = (load_state != bdrb_pkg::BDRB_IDLE);
  assign wr_ok = reg_wr && !reg_busy;
  assign ctrl_wr = wr_ok && (reg_addr == bdrb_pkg::OFS_GLOBAL_CONTROL);
  assign key_wr = wr_ok && (reg_addr == bdrb_pkg::OFS_UNLOCK_KEY);
  assign dac_wr = wr_ok && override_mode && is_dac_addr(reg_addr);

  // a refused write: busy, or a DAC write outside override mode
  always_comb begin
    reg_wr_refused = 1'b0;
    if (reg_wr && reg_busy) begin
      reg_wr_refused = 1'b1;
    end else if (reg_wr && is_dac_addr(reg_addr) && !override_mode) begin
      reg_wr_refused = 1'b1;
    end
  end

  assign soft_rst_req = ctrl_wr && reg_wdata[bdrb_pkg::CTRL_SOFT_RST_BIT];
  // soft reset already includes the reload, so it takes precedence
  assign refresh_req = ctrl_wr && reg_wdata[bdrb_pkg::CTRL_REFRESH_BIT] &&
                       !soft_rst_req;
  assign reload_start = soft_rst_req || refresh_req;

  // ****************************************************************
  // global control request bits
  // ****************************************************************
  // the request bits keep what the host wrote; the host clears them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_req <= bdrb_pkg::CTRL_REQ_RST;
    end else if (ctrl_wr) begin
      ctrl_req <= {reg_wdata[bdrb_pkg::CTRL_SOFT_RST_BIT],
                   reg_wdata[bdrb_pkg::CTRL_REFRESH_BIT]};
    end
  end

  // ****************************************************************
  // override mode
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      override_mode <= 1'b0;
    end else if (soft_rst_req) begin
      override_mode <= 1'b0;
    end else if (key_wr) begin
      if (reg_wdata == bdrb_pkg::UNLOCK_KEY) begin
        override_mode <= 1'b1;
      end else begin
        override_mode <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // fuse copy sequencer
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      load_state <= bdrb_pkg::BDRB_SETTLE;
    end else begin
      load_state <= next_load_state;
    end
  end

  always_comb begin
    next_load_state = load_state;
    case (load_state)
      bdrb_pkg::BDRB_IDLE: begin
        if (reload_start) begin
          next_load_state = bdrb_pkg::BDRB_SETTLE;
        end
      end
      bdrb_pkg::BDRB_SETTLE: begin
        if (settle_cnt == bdrb_pkg::SETTLE_CYCLES - 3'h1) begin
          next_load_state = bdrb_pkg::BDRB_COPY;
        end
      end
      bdrb_pkg::BDRB_COPY: begin
        next_load_state = bdrb_pkg::BDRB_IDLE;
      end
      default: begin
        next_load_state = bdrb_pkg::BDRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      settle_cnt <= 3'h0;
    end else if (load_state == bdrb_pkg::BDRB_SETTLE) begin
      settle_cnt <= settle_cnt + 3'h1;
    end else begin
      settle_cnt <= 3'h0;
    end
  end

  // shows whether the last copy took fuse values or the defaults
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fuse_loaded <= 1'b0;
    end else if (load_state == bdrb_pkg::BDRB_COPY) begin
      fuse_loaded <= otp_sync.programmed;
    end
  end

  // ****************************************************************
  // DAC setting registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dac <= bdrb_pkg::DAC_RST;
    end else if (soft_rst_req) begin
      dac <= bdrb_pkg::DAC_RST;
    end else if (load_state == bdrb_pkg::BDRB_COPY) begin
      if (otp_sync.programmed) begin
        dac <= otp_sync.dac;
      end else begin
        dac <= bdrb_pkg::DAC_RST;
      end
    end else if (dac_wr) begin
      case (reg_addr)
        bdrb_pkg::OFS_CARRIER_REF: begin
          dac.carrier_ref <= reg_wdata[5:0];
        end
        bdrb_pkg::OFS_CARRIER_DRV: begin
          dac.carrier_drv <= reg_wdata;
        end
        bdrb_pkg::OFS_CARRIER_FIN: begin
          dac.carrier_fin <= reg_wdata;
        end
        bdrb_pkg::OFS_PEAKING_REF: begin
          dac.peaking_ref <= reg_wdata[5:0];
        end
        bdrb_pkg::OFS_PEAKING_DRV: begin
          dac.peaking_drv <= reg_wdata;
        end
        bdrb_pkg::OFS_PEAKING_FIN: begin
          dac.peaking_fin <= reg_wdata;
        end
        default: begin
          dac <= dac;
        end
      endcase
    end
  end

  // codes go to the converters unchanged; the analog side maps a larger
  // offset code to a lower gate voltage, so no range check is applied
  // here and a low reference level is the host's responsibility
  assign dac_out = dac;

  // ****************************************************************
  // thermal reading
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      thermal_reading <= bdrb_pkg::THERMAL_RST;
    end else if (soft_rst_req) begin
      thermal_reading <= bdrb_pkg::THERMAL_RST;
    end else begin
      thermal_reading <= thermal_sync;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // reads are served at any time, also during a fuse copy
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      bdrb_pkg::OFS_GLOBAL_CONTROL: begin
        next_rdata[bdrb_pkg::CTRL_SOFT_RST_BIT] = ctrl_req[1];
        next_rdata[bdrb_pkg::CTRL_REFRESH_BIT] = ctrl_req[0];
        next_rdata[bdrb_pkg::CTRL_REV_LSB +: bdrb_pkg::CTRL_REV_W] =
          bdrb_pkg::REVISION_CODE;
      end
      bdrb_pkg::OFS_CARRIER_REF: begin
        next_rdata = pad6(dac.carrier_ref);
      end
      bdrb_pkg::OFS_CARRIER_DRV: begin
        next_rdata = dac.carrier_drv;
      end
      bdrb_pkg::OFS_CARRIER_FIN: begin
        next_rdata = dac.carrier_fin;
      end
      bdrb_pkg::OFS_PEAKING_REF: begin
        next_rdata = pad6(dac.peaking_ref);
      end
      bdrb_pkg::OFS_PEAKING_DRV: begin
        next_rdata = dac.peaking_drv;
      end
      bdrb_pkg::OFS_PEAKING_FIN: begin
        next_rdata = dac.peaking_fin;
      end
      bdrb_pkg::OFS_THERMAL: begin
        next_rdata = thermal_reading;
      end
      default: begin
        // the unlock key is write only and reserved space is empty
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

endmodule

// ---- verification/bdrb_bank_asserts.sv ----
`timescale 1ns/10ps
// ****
// port checks for the register bank
// ****
module bdrb_bank_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_busy,
  input wire logic reg_wr_refused,
  input wire bdrb_pkg::bdrb_otp_s otp_in,
  input wire logic [7:0] thermal_in,
  input wire bdrb_pkg::bdrb_dac_s dac_out,
  input wire logic override_mode,
  input wire logic fuse_loaded
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic wr_ok;
  logic key_wr;
  assign wr_ok = reg_wr && !reg_busy;
  assign key_wr = wr_ok && reg_addr == bdrb_pkg::OFS_UNLOCK_KEY;
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  AST_UNLOCK: assert property (
    key_wr && reg_wdata == bdrb_pkg::UNLOCK_KEY |=> override_mode)
    else $error("key did not unlock");
  AST_LOCK: assert property (
    key_wr && reg_wdata != bdrb_pkg::UNLOCK_KEY |=> !override_mode)
    else $error("wrong key kept override");
  AST_REFUSE: assert property (
    wr_ok && !override_mode && reg_addr inside {[1:6]}
    |-> reg_wr_refused ##1 $stable(dac_out))
    else $error("locked dac write took effect");
  AST_ACCEPT_DRV: assert property (
    wr_ok && override_mode && reg_addr == bdrb_pkg::OFS_CARRIER_DRV
    |=> dac_out.carrier_drv == $past(reg_wdata))
    else $error("driver offset write lost");
  AST_ACCEPT_REF: assert property (
    wr_ok && override_mode && reg_addr == bdrb_pkg::OFS_PEAKING_REF
    |=> dac_out.peaking_ref == $past(reg_wdata[5:0]))
    else $error("reference write lost");
  AST_SOFT_RST: assert property (
    wr_ok && reg_addr == 5'h00 && reg_wdata[6]
    |=> dac_out == bdrb_pkg::DAC_RST && !override_mode && reg_busy)
    else $error("soft reset missed");
  AST_COPY: assert property ($fell(reg_busy) |->
    dac_out == (otp_in.programmed ? otp_in.dac : bdrb_pkg::DAC_RST))
    else $error("fuse copy wrong");
  AST_BUSY_BOUND: assert property (reg_busy |-> ##[1:8] !reg_busy)
    else $error("busy too long");
  AST_CTRL_RD: assert property (reg_rd && reg_addr == 5'h00 |=>
    reg_rdata[3:0] == bdrb_pkg::REVISION_CODE && !reg_rdata[7] && !reg_rdata[4])
    else $error("control read wrong");
  AST_RESV_RD: assert property (
    reg_rd && reg_addr inside {[7:14], 16, 17} |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  C_UNLOCK: cover property (key_wr && reg_wdata == bdrb_pkg::UNLOCK_KEY);
  C_REFUSE: cover property (reg_wr_refused);
  C_COPY: cover property ($fell(reg_busy) && otp_in.programmed);
endmodule

bind bdrb_bank bdrb_bank_asserts i_chk (.core_clk, .nrst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .reg_busy, .reg_wr_refused,
  .otp_in, .thermal_in, .dac_out, .override_mode, .fuse_loaded);

// ---- verification/bdrb_host.sv ----
`timescale 1ns/10ps
// ****
// host side of the register port
// ****
module bdrb_host (
  input wire logic core_clk,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = x;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // scrambled after release so a stale byte never looks valid
    reg_wdata = ~x;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] x,
                    output logic ok);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    x = reg_rdata;
    ok = reg_rvalid;
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
// ****
// register bank bench
// ****
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, reg_busy, reg_wr_refused;
  logic [7:0] reg_wdata, reg_rdata, thermal_in, d, x;
  logic override_mode, fuse_loaded, v;
  bdrb_pkg::bdrb_otp_s otp_in;
  bdrb_pkg::bdrb_dac_s dac_out, exp_dac;
  logic [1:0] ctl;
  int n_errors = 0;
  int checks = 0;
  always #12.5 core_clk = ~core_clk;
  bdrb_bank i_dut (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_rvalid, .reg_busy, .reg_wr_refused, .otp_in,
    .thermal_in, .dac_out, .override_mode, .fuse_loaded);
  bdrb_host i_host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid);
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [4:0] a);
    case (a)
      5'h00: exp_rd = {1'b0, ctl, 1'b0, bdrb_pkg::REVISION_CODE};
      5'h01: exp_rd = {2'h0, exp_dac.carrier_ref};
      5'h02: exp_rd = exp_dac.carrier_drv;
      5'h03: exp_rd = exp_dac.carrier_fin;
      5'h04: exp_rd = {2'h0, exp_dac.peaking_ref};
      5'h05: exp_rd = exp_dac.peaking_drv;
      5'h06: exp_rd = exp_dac.peaking_fin;
      5'h0F: exp_rd = thermal_in;
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task automatic rc(input logic [4:0] a);
    i_host.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, exp_rd(a));
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 20 && reg_busy !== 1'b0; i++)
      @(negedge core_clk);
    if (reg_busy !== 1'b0) begin
      n_errors++;
      conclude();
    end
  endtask
  // override writes to every dac register with fresh random codes
  task automatic fill_dac();
    for (int a = 1; a < 7; a++) begin
      x = 8'($urandom);
      if (a == 1 || a == 4)
        x[5:0] = 6'h11 + 6'($urandom % 47);
      i_host.wr(a[4:0], x);
      case (a)
        1: exp_dac.carrier_ref = x[5:0];
        2: exp_dac.carrier_drv = x;
        3: exp_dac.carrier_fin = x;
        4: exp_dac.peaking_ref = x[5:0];
        5: exp_dac.peaking_drv = x;
        default: exp_dac.peaking_fin = x;
      endcase
      rc(a[4:0]);
    end
  endtask
  initial begin
    d = $urandom(32'hD6CD2EC5);
    otp_in = '0;
    thermal_in = 8'($urandom);
    ctl = 2'h0;
    exp_dac = bdrb_pkg::DAC_RST;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    wait_idle();
    chk(dac_out, exp_dac);
    chk(fuse_loaded, 1'b0);
    for (int a = 0; a < 18; a++)
      rc(a[4:0]);
    i_host.wr(5'h00, 8'h9F);
    rc(5'h00);
    i_host.wr(5'h02, 8'($urandom));
    rc(5'h02);
    for (int a = 7; a < 17; a++)
      i_host.wr(a[4:0], 8'($urandom));
    for (int a = 7; a < 18; a++)
      rc(a[4:0]);
    i_host.wr(5'h11, bdrb_pkg::UNLOCK_KEY);
    chk(override_mode, 1'b1);
    fill_dac();
    chk(dac_out, exp_dac);
    x = 8'($urandom);
    if (x == bdrb_pkg::UNLOCK_KEY)
      x = 8'h00;
    i_host.wr(5'h11, x);
    chk(override_mode, 1'b0);
    i_host.wr(5'h03, ~exp_dac.carrier_fin);
    rc(5'h03);
    otp_in = {1'b1, 12'($urandom), 32'($urandom)};
    i_host.wr(5'h11, bdrb_pkg::UNLOCK_KEY);
    fill_dac();
    i_host.wr(5'h00, 8'h20);
    ctl = 2'h1;
    wait_idle();
    exp_dac = otp_in.dac;
    chk(dac_out, exp_dac);
    chk(fuse_loaded, 1'b1);
    rc(5'h00);
    i_host.wr(5'h00, 8'h00);
    ctl = 2'h0;
    fill_dac();
    i_host.wr(5'h00, 8'h60);
    ctl = 2'h3;
    wait_idle();
    // soft reset loads defaults, then the fuse copy replaces them
    exp_dac = otp_in.dac;
    chk(dac_out, exp_dac);
    chk(override_mode, 1'b0);
    rc(5'h00);
    i_host.wr(5'h00, 8'h00);
    ctl = 2'h0;
    i_host.wr(5'h11, bdrb_pkg::UNLOCK_KEY);
    fill_dac();
    otp_in.dac = {12'($urandom), 32'($urandom)};
    repeat (6) @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    wait_idle();
    exp_dac = otp_in.dac;
    chk(override_mode, 1'b0);
    chk(dac_out, exp_dac);
    i_host.wr(5'h01, 8'h3F);
    rc(5'h01);
    conclude();
  end
endmodule
